// ### inc/ea_calc_map.svh
`ifndef EA_CALC_MAP_SVH
`define EA_CALC_MAP_SVH

`define EA_AW 32
`define EA_CW 5

`define EA_CNT_ONE 5'h01
`define EA_STALL_NONE 5'h00

`define EA_T_SIMPLE 5'h01
`define EA_T_PC_D16 5'h03
`define EA_T_BRIEF_AN 5'h03
`define EA_S_BRIEF_AN 5'h03
`define EA_T_BRIEF_PC 5'h05
`define EA_S_BRIEF_PC 5'h04

`define EA_T_FULL_IDX 5'h06
`define EA_T_FULL_IDX_BD 5'h07
`define EA_T_FULL_MEM 5'h09
`define EA_T_FULL_MEM_OD 5'h0A
`define EA_T_FULL_POST_X 5'h0A
`define EA_T_FULL_POST_X_OD 5'h0B
`define EA_S_FULL 5'h04
`define EA_S_FULL_POST_X 5'h06

`define EA_BYTE_STEP 32'h00000001
`define EA_WORD_STEP 32'h00000002
`define EA_LONG_STEP 32'h00000004

`define EA_BYTE_MASK 32'h000000FF
`define EA_WORD_MASK 32'h0000FFFF

`define EA_B_MSB 7
`define EA_W_MSB 15

`define EA_FETCH_ONE 2'h1
`define EA_FETCH_TWO 2'h2

`endif

// ### inc/ea_calc_pkg.sv
package ea_calc_pkg;

  typedef enum logic [3:0] {
    MODE_DREG = 4'h0,
    MODE_AREG = 4'h1,
    MODE_IND = 4'h2,
    MODE_POSTINC = 4'h3,
    MODE_PREDEC = 4'h4,
    MODE_DISP16 = 4'h5,
    MODE_IDX_BRIEF = 4'h6,
    MODE_IDX_FULL = 4'h7,
    MODE_MEM_PRE = 4'h8,
    MODE_MEM_POST = 4'h9,
    MODE_PC_DISP16 = 4'hA,
    MODE_PC_IDX_BRIEF = 4'hB,
    MODE_ABS_W = 4'hC,
    MODE_ABS_L = 4'hD,
    MODE_IMM = 4'hE
  } ea_mode_t;

  typedef enum logic [1:0] {
    DISP_NONE = 2'h0,
    DISP_WORD = 2'h1,
    DISP_LONG = 2'h2
  } disp_size_t;

  typedef enum logic [1:0] {
    SIZE_BYTE = 2'h0,
    SIZE_WORD = 2'h1,
    SIZE_LONG = 2'h2
  } op_size_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_CALC = 2'h1
  } ea_state_t;

  typedef struct packed {
    ea_mode_t mode;
    logic base_pc;
    logic base_sup;
    logic idx_sup;
    logic idx_long;
    logic [1:0] idx_scale;
    disp_size_t bd_size;
    disp_size_t od_size;
    logic fiea;
    op_size_t op_size;
    logic [31:0] address_reg_operand;
    logic [31:0] index_reg_operand;
    logic [31:0] pc;
    logic [31:0] disp;
    logic [31:0] outer_displacement;
    logic [31:0] ext_word;
  } ea_req_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] areg_next;
    logic areg_wr;
    logic is_reg;
    logic is_imm;
    logic [31:0] imm_data;
    logic [4:0] table_clocks;
    logic [4:0] stall_clock;
    logic [4:0] used_clocks;
    logic [1:0] fetch_clocks;
  } ea_resp_t;

endpackage

// ### src/ea_calc_stage.sv
`timescale 1ns/10ps
`include "ea_calc_map.svh"
module ea_calc_stage (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic req_valid,
  input wire ea_calc_pkg::ea_req_t req,
  output logic req_ready,
  input wire logic eu_prev_done,
  output logic ptr_rd_req,
  output logic [31:0] ptr_rd_addr,
  input wire logic ptr_rd_ack,
  input wire logic [31:0] ptr_rd_data,
  output logic resp_valid,
  output ea_calc_pkg::ea_resp_t resp
);
  import ea_calc_pkg::*;

  ea_state_t state_r;
  ea_state_t state_nxt;
  ea_req_t req_r;
  logic [4:0] cnt_r;
  logic [4:0] used_r;
  logic ptr_got_r;
  logic [31:0] ptr_r;
  logic resp_valid_r;
  ea_resp_t resp_r;

  wire is_full = (req_r.mode == MODE_IDX_FULL) || (req_r.mode == MODE_MEM_PRE) ||
                 (req_r.mode == MODE_MEM_POST);
  wire is_mem_ind = (req_r.mode == MODE_MEM_PRE) || (req_r.mode == MODE_MEM_POST);
  wire has_od = req_r.od_size != DISP_NONE;
  wire has_bd = req_r.bd_size != DISP_NONE;

  // Base count per form before the immediate and PC adjustments.
  wire [4:0] full_post_clk = req_r.idx_sup ?
    (has_od ? `EA_T_FULL_MEM_OD : `EA_T_FULL_MEM) :
    (has_od ? `EA_T_FULL_POST_X_OD : `EA_T_FULL_POST_X);
  wire [4:0] full_base_clk =
    (req_r.mode == MODE_IDX_FULL) ? (has_bd ? `EA_T_FULL_IDX_BD : `EA_T_FULL_IDX) :
    (req_r.mode == MODE_MEM_PRE) ? (has_od ? `EA_T_FULL_MEM_OD : `EA_T_FULL_MEM) :
    full_post_clk;
  wire [4:0] full_base_stall = ((req_r.mode == MODE_MEM_POST) && !req_r.idx_sup) ?
    `EA_S_FULL_POST_X : `EA_S_FULL;
  // The column is picked by the encoded base even when the base is suppressed.
  wire [4:0] full_adj = 5'((req_r.fiea ? 1 : 0) + (req_r.base_pc ? 1 : 0));

  wire [4:0] table_clk =
    is_full ? 5'(full_base_clk + full_adj) :
    (req_r.mode == MODE_PC_DISP16) ? `EA_T_PC_D16 :
    (req_r.mode == MODE_IDX_BRIEF) ? `EA_T_BRIEF_AN :
    (req_r.mode == MODE_PC_IDX_BRIEF) ? `EA_T_BRIEF_PC :
    `EA_T_SIMPLE;
  wire [4:0] stall_clk =
    is_full ? 5'(full_base_stall + full_adj) :
    (req_r.mode == MODE_IDX_BRIEF) ? `EA_S_BRIEF_AN :
    (req_r.mode == MODE_PC_IDX_BRIEF) ? `EA_S_BRIEF_PC :
    `EA_STALL_NONE;

  // Operand values.
  wire [31:0] idx_ext = req_r.idx_long ? req_r.index_reg_operand :
    {{16{req_r.index_reg_operand[`EA_W_MSB]}}, req_r.index_reg_operand[`EA_W_MSB:0]};
  wire [31:0] idx_scaled = idx_ext << req_r.idx_scale;
  wire [31:0] idx_term = req_r.idx_sup ? 32'h00000000 : idx_scaled;
  wire [31:0] byte_displacement = {{24{req_r.disp[`EA_B_MSB]}}, req_r.disp[`EA_B_MSB:0]};
  wire [31:0] word_displacement = {{16{req_r.disp[`EA_W_MSB]}}, req_r.disp[`EA_W_MSB:0]};
  wire [31:0] base_displacement = (req_r.bd_size == DISP_LONG) ? req_r.disp :
    (req_r.bd_size == DISP_WORD) ? word_displacement : 32'h00000000;
  wire [31:0] od_word = {{16{req_r.outer_displacement[`EA_W_MSB]}},
                         req_r.outer_displacement[`EA_W_MSB:0]};
  wire [31:0] od_val = (req_r.od_size == DISP_LONG) ? req_r.outer_displacement :
    (req_r.od_size == DISP_WORD) ? od_word : 32'h00000000;
  wire [31:0] full_base = req_r.base_sup ? 32'h00000000 :
    (req_r.base_pc ? req_r.pc : req_r.address_reg_operand);
  wire [31:0] step = (req_r.op_size == SIZE_BYTE) ? `EA_BYTE_STEP :
    (req_r.op_size == SIZE_WORD) ? `EA_WORD_STEP : `EA_LONG_STEP;

  // Intermediate address for the pointer read, final address after it.
  wire [31:0] pre_idx = ((req_r.mode == MODE_MEM_PRE) || (req_r.mode == MODE_IDX_FULL)) ?
    idx_term : 32'h00000000;
  wire [31:0] post_idx = (req_r.mode == MODE_MEM_POST) ? idx_term : 32'h00000000;
  wire [31:0] inter_addr = full_base + base_displacement + pre_idx;
  wire [31:0] ind_addr = ptr_r + post_idx + od_val;
  wire [31:0] predec_addr = req_r.address_reg_operand - step;
  wire [31:0] postinc_next = req_r.address_reg_operand + step;
  wire [31:0] abs_w_addr = {{16{req_r.ext_word[`EA_W_MSB]}}, req_r.ext_word[`EA_W_MSB:0]};

  logic [31:0] addr_sel;
  always_comb begin
    unique case (req_r.mode)
      MODE_IND: addr_sel = req_r.address_reg_operand;
      MODE_POSTINC: addr_sel = req_r.address_reg_operand;
      MODE_PREDEC: addr_sel = predec_addr;
      MODE_DISP16: addr_sel = req_r.address_reg_operand + word_displacement;
      MODE_IDX_BRIEF: addr_sel = req_r.address_reg_operand + byte_displacement + idx_term;
      MODE_IDX_FULL: addr_sel = inter_addr;
      MODE_MEM_PRE: addr_sel = ind_addr;
      MODE_MEM_POST: addr_sel = ind_addr;
      MODE_PC_DISP16: addr_sel = req_r.pc + word_displacement;
      MODE_PC_IDX_BRIEF: addr_sel = req_r.pc + byte_displacement + idx_term;
      MODE_ABS_W: addr_sel = abs_w_addr;
      MODE_ABS_L: addr_sel = req_r.ext_word;
      default: addr_sel = 32'h00000000;
    endcase
  end

  wire [31:0] imm_val = (req_r.op_size == SIZE_BYTE) ? (req_r.ext_word & `EA_BYTE_MASK) :
    (req_r.op_size == SIZE_WORD) ? (req_r.ext_word & `EA_WORD_MASK) : req_r.ext_word;
  wire is_reg = (req_r.mode == MODE_DREG) || (req_r.mode == MODE_AREG);
  wire is_imm = req_r.mode == MODE_IMM;
  wire [1:0] fetch_clk = is_mem_ind ? `EA_FETCH_TWO : `EA_FETCH_ONE;

  // Sequencing: stall point, pointer read, then completion.
  wire in_calc = state_r == ST_CALC;
  wire eu_stall = in_calc && (cnt_r == stall_clk) && !eu_prev_done;
  wire ptr_clk = in_calc && is_mem_ind && !ptr_got_r && (cnt_r > stall_clk);
  wire ptr_wait = ptr_clk && !ptr_rd_ack;
  wire hold = eu_stall || ptr_wait;
  wire at_end = in_calc && (cnt_r >= table_clk) && !hold;
  wire accept = req_valid && req_ready;

  // A new request is taken in the clock the previous result leaves.
  assign req_ready = (state_r == ST_IDLE) || at_end;
  assign ptr_rd_req = ptr_clk && !eu_stall;
  assign ptr_rd_addr = inter_addr;
  assign resp_valid = resp_valid_r;
  assign resp = resp_r;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: begin
        if (accept) begin
          state_nxt = ST_CALC;
        end
      end
      ST_CALC: begin
        if (at_end && !accept) begin
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  wire [4:0] cnt_nxt = accept ? `EA_CNT_ONE :
    (in_calc && (cnt_r < table_clk) && !hold) ? 5'(cnt_r + 5'h01) : cnt_r;
  wire [4:0] used_nxt = accept ? `EA_CNT_ONE : in_calc ? 5'(used_r + 5'h01) : used_r;
  wire ptr_got_nxt = accept ? 1'b0 : (ptr_rd_req && ptr_rd_ack) ? 1'b1 : ptr_got_r;

  ea_resp_t resp_nxt;
  always_comb begin
    resp_nxt = resp_r;
    if (at_end) begin
      resp_nxt.addr = addr_sel;
      resp_nxt.areg_next = (req_r.mode == MODE_PREDEC) ? predec_addr : postinc_next;
      resp_nxt.areg_wr = (req_r.mode == MODE_PREDEC) || (req_r.mode == MODE_POSTINC);
      resp_nxt.is_reg = is_reg;
      resp_nxt.is_imm = is_imm;
      resp_nxt.imm_data = is_imm ? imm_val : 32'h00000000;
      resp_nxt.table_clocks = table_clk;
      resp_nxt.stall_clock = stall_clk;
      resp_nxt.used_clocks = used_r;
      resp_nxt.fetch_clocks = fetch_clk;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= ST_IDLE;
      req_r <= '0;
      cnt_r <= 5'h00;
      used_r <= 5'h00;
      ptr_got_r <= 1'b0;
      ptr_r <= 32'h00000000;
      resp_valid_r <= 1'b0;
      resp_r <= '0;
    end else begin
      state_r <= state_nxt;
      req_r <= accept ? req : req_r;
      cnt_r <= cnt_nxt;
      used_r <= used_nxt;
      ptr_got_r <= ptr_got_nxt;
      ptr_r <= (ptr_rd_req && ptr_rd_ack) ? ptr_rd_data : ptr_r;
      resp_valid_r <= at_end;
      resp_r <= resp_nxt;
    end
  end

endmodule

// ### dv/ea_calc_stage_sva.sv
`timescale 1ns/10ps
module ea_calc_stage_sva (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic req_valid,
  input wire ea_calc_pkg::ea_req_t req,
  input wire logic req_ready,
  input wire logic eu_prev_done,
  input wire logic ptr_rd_req,
  input wire logic [31:0] ptr_rd_addr,
  input wire logic ptr_rd_ack,
  input wire logic [31:0] ptr_rd_data,
  input wire logic resp_valid,
  input wire ea_calc_pkg::ea_resp_t resp
);
  import ea_calc_pkg::*;
  wire tk = req_valid && req_ready;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  chk_dreg_time: assert property (tk && req.mode == MODE_DREG |-> ##2 resp_valid && resp.is_reg && resp.table_clocks == 5'h01)
    else $error("register direct timing wrong");
  chk_pcd_time: assert property (tk && req.mode == MODE_PC_DISP16 |-> ##4 resp_valid && resp.table_clocks == 5'h03)
    else $error("pc displacement timing wrong");
  chk_postinc_addr: assert property (tk && req.mode == MODE_POSTINC |-> ##2 resp_valid && resp.areg_wr && resp.addr == $past(req.address_reg_operand, 2))
    else $error("postincrement address wrong");
  chk_abs_sext: assert property (tk && req.mode == MODE_ABS_W |-> ##2 resp.addr == {{16{$past(req.ext_word[15], 2)}}, $past(req.ext_word[15:0], 2)})
    else $error("short absolute not extended");
  chk_brief_go: assert property (tk && req.mode == MODE_IDX_BRIEF ##3 eu_prev_done |=> resp_valid && resp.stall_clock == 5'h03)
    else $error("brief index not done at clock 3");
  chk_brief_stall: assert property (tk && req.mode == MODE_IDX_BRIEF ##3 !eu_prev_done |=> !resp_valid)
    else $error("brief index did not stall");
  chk_ptr_hold: assert property (ptr_rd_req && !ptr_rd_ack |=> ptr_rd_req && $stable(ptr_rd_addr))
    else $error("pointer read dropped early");
  chk_ptr_late: assert property (tk && req.mode inside {MODE_MEM_PRE, MODE_MEM_POST} |=> !ptr_rd_req [*4])
    else $error("pointer read before stall point");
  chk_miss_long: assert property (resp_valid |-> resp.used_clocks >= resp.table_clocks)
    else $error("used clocks below table");
  chk_fetch_cnt: assert property (resp_valid |-> (resp.fetch_clocks == 2'h1) ||
    ((resp.fetch_clocks == 2'h2) && (resp.table_clocks >= 5'h09)))
    else $error("fetch clocks out of range");
  cover property (tk && req.mode == MODE_MEM_PRE);
  cover property (ptr_rd_req && !ptr_rd_ack);
  cover property (resp_valid && resp.used_clocks > resp.table_clocks);
endmodule

bind ea_calc_stage ea_calc_stage_sva chk_u (.clk, .rst_b, .req_valid, .req, .req_ready,
  .eu_prev_done, .ptr_rd_req, .ptr_rd_addr, .ptr_rd_ack, .ptr_rd_data, .resp_valid, .resp);

// ### dv/ptr_mem_model.sv
`timescale 1ns/10ps
module ptr_mem_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [3:0] wait_cycles,
  input wire logic ptr_rd_req,
  input wire logic [31:0] ptr_rd_addr,
  output logic ptr_rd_ack,
  output logic [31:0] ptr_rd_data
);
  logic [3:0] cnt_r;
  logic [31:0] junk_r;
  // A slow answer models a data cache miss.
  assign ptr_rd_ack = ptr_rd_req && (cnt_r == wait_cycles);
  // The pointer is a whole long word; outside an answer the bus churns.
  assign ptr_rd_data = ptr_rd_ack ? (ptr_rd_addr ^ 32'h5A5A0000) : junk_r;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= 4'h0;
      junk_r <= 32'h0;
    end else begin
      cnt_r <= (ptr_rd_req && !ptr_rd_ack) ? cnt_r + 4'h1 : 4'h0;
      junk_r <= ~junk_r;
    end
  end
endmodule

// ### dv/ea_calc_stage_tb.sv
`timescale 1ns/10ps
module ea_calc_stage_tb;
  import ea_calc_pkg::*;
  logic clk, rst_b, req_valid, req_ready, eu_prev_done;
  logic ptr_rd_req, ptr_rd_ack, resp_valid;
  logic [31:0] ptr_rd_addr, ptr_rd_data;
  logic [3:0] wait_cycles;
  ea_req_t req, r;
  ea_resp_t resp, rsp;
  int failures, n_compared;
  ea_calc_stage dut_u (.clk(clk), .rst_b(rst_b), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .eu_prev_done(eu_prev_done), .ptr_rd_req(ptr_rd_req),
    .ptr_rd_addr(ptr_rd_addr), .ptr_rd_ack(ptr_rd_ack), .ptr_rd_data(ptr_rd_data),
    .resp_valid(resp_valid), .resp(resp));
  ptr_mem_model mem_u (.clk(clk), .rst_b(rst_b), .wait_cycles(wait_cycles),
    .ptr_rd_req(ptr_rd_req), .ptr_rd_addr(ptr_rd_addr), .ptr_rd_ack(ptr_rd_ack),
    .ptr_rd_data(ptr_rd_data));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic print_verdict;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic cmp_v(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic cmp_t(input logic [4:0] t, input logic [4:0] s, input logic [4:0] u);
    cmp_v({17'h0, rsp.table_clocks, rsp.stall_clock, rsp.used_clocks}, {17'h0, t, s, u});
  endtask
  task automatic run(input int h);
    int n;
    n = 0;
    req = r;
    req_valid = 1'b1;
    eu_prev_done = (h == 0);
    while (req_ready !== 1'b1) begin
      @(negedge clk);
      n++;
      if (n > 50) begin
        failures++;
        print_verdict();
      end
    end
    @(negedge clk);
    req_valid = 1'b0;
    n = 0;
    while (resp_valid !== 1'b1) begin
      @(negedge clk);
      n++;
      if (n >= h) eu_prev_done = 1'b1;
      if (n > 60) begin
        failures++;
        print_verdict();
      end
    end
    rsp = resp;
  endtask
  task automatic t_areg;
    r = '0;
    r.mode = MODE_POSTINC;
    r.op_size = SIZE_LONG;
    r.address_reg_operand = 32'h00001000;
    run(0);
    cmp_v(rsp.areg_next, 32'h00001004);
    r.mode = MODE_PREDEC;
    r.op_size = SIZE_WORD;
    run(0);
    cmp_v(rsp.addr, 32'h00000FFE);
    r.mode = MODE_ABS_W;
    r.ext_word = 32'h00008010;
    run(0);
    cmp_v(rsp.addr, 32'hFFFF8010);
    r.mode = MODE_ABS_L;
    r.ext_word = 32'h87654320;
    run(0);
    cmp_v(rsp.addr, 32'h87654320);
    r.mode = MODE_DISP16;
    r.disp = 32'h0000FFF0;
    run(0);
    cmp_v(rsp.addr, 32'h00000FF0);
    r.mode = MODE_AREG;
    run(0);
    cmp_v({31'h0, rsp.is_reg}, 32'h00000001);
    cmp_t(5'h01, 5'h00, 5'h01);
  endtask
  task automatic t_brief;
    r = '0;
    r.mode = MODE_IDX_BRIEF;
    r.address_reg_operand = 32'h00002000;
    r.index_reg_operand = 32'h0000FFFD;
    r.idx_scale = 2'h3;
    r.disp = 32'h000000FE;
    run(4);
    cmp_v(rsp.addr, 32'h00001FE6);
    cmp_t(5'h03, 5'h03, 5'h05);
    r.idx_long = 1'b0;
    r.idx_scale = 2'h0;
    r.index_reg_operand = 32'h0001FFF0;
    r.disp = 32'h00000005;
    run(0);
    cmp_v(rsp.addr, 32'h00001FF5);
  endtask
  task automatic t_pc;
    r = '0;
    r.mode = MODE_PC_IDX_BRIEF;
    r.pc = 32'h00004000;
    r.index_reg_operand = 32'h00000002;
    r.idx_scale = 2'h1;
    r.disp = 32'h00000080;
    run(0);
    cmp_v(rsp.addr, 32'h00003F84);
    cmp_t(5'h05, 5'h04, 5'h05);
    r.mode = MODE_PC_DISP16;
    r.disp = 32'h0000FFF0;
    run(0);
    cmp_v(rsp.addr, 32'h00003FF0);
  endtask
  task automatic t_mem;
    r = '0;
    r.mode = MODE_MEM_PRE;
    r.address_reg_operand = 32'h00000100;
    r.bd_size = DISP_LONG;
    r.disp = 32'h00000010;
    r.idx_long = 1'b1;
    r.index_reg_operand = 32'h00000004;
    r.od_size = DISP_LONG;
    r.outer_displacement = 32'h00000020;
    wait_cycles = 4'h2;
    run(0);
    cmp_v(rsp.addr, 32'h5A5A0134);
    cmp_t(5'h0A, 5'h04, 5'h0C);
    cmp_v({30'h0, rsp.fetch_clocks}, 32'h00000002);
    r.base_sup = 1'b1;
    r.base_pc = 1'b1;
    r.fiea = 1'b1;
    r.od_size = DISP_NONE;
    wait_cycles = 4'h0;
    run(0);
    cmp_v(rsp.addr, 32'h5A5A0014);
    cmp_t(5'h0B, 5'h06, 5'h0B);
  endtask
  task automatic t_imm;
    r = '0;
    r.mode = MODE_IMM;
    r.ext_word = 32'h12345687;
    for (int i = 0; i < 3; i++) begin
      r.op_size = op_size_t'(i);
      run(0);
      cmp_v(rsp.imm_data, i == 0 ? 32'h00000087 : i == 1 ? 32'h00005687 : 32'h12345687);
      cmp_v({31'h0, rsp.is_imm}, 32'h00000001);
    end
  endtask
  task automatic t_full;
    r = '0;
    r.mode = MODE_IDX_FULL;
    r.address_reg_operand = 32'h00003000;
    r.bd_size = DISP_WORD;
    r.disp = 32'h0000FFFC;
    r.index_reg_operand = 32'h00000008;
    r.idx_scale = 2'h2;
    run(6);
    cmp_v(rsp.addr, 32'h0000301C);
    cmp_t(5'h07, 5'h04, 5'h0A);
    r = '0;
    r.mode = MODE_MEM_POST;
    r.address_reg_operand = 32'h00000200;
    r.index_reg_operand = 32'h00000010;
    r.idx_scale = 2'h1;
    r.od_size = DISP_WORD;
    r.outer_displacement = 32'h0000FFF8;
    wait_cycles = 4'h0;
    run(0);
    cmp_v(rsp.addr, 32'h5A5A0218);
    cmp_t(5'h0B, 5'h06, 5'h0B);
  endtask
  task automatic t_overlap;
    r = '0;
    r.mode = MODE_DREG;
    req = r;
    req_valid = 1'b1;
    @(negedge clk);
    cmp_v({31'h0, req_ready}, 32'h00000001);
    r.mode = MODE_IND;
    r.address_reg_operand = 32'h00007000;
    req = r;
    @(negedge clk);
    req_valid = 1'b0;
    cmp_v({30'h0, resp_valid, resp.is_reg}, 32'h00000003);
    cmp_v({27'h0, resp.table_clocks}, 32'h00000001);
    @(negedge clk);
    cmp_v({31'h0, resp_valid}, 32'h00000001);
    cmp_v(resp.addr, 32'h00007000);
    @(negedge clk);
  endtask
  initial begin
    rst_b = 1'b0;
    req_valid = 1'b0;
    req = '0;
    r = '0;
    eu_prev_done = 1'b1;
    wait_cycles = 4'h0;
    repeat (16) @(negedge clk);
    rst_b = 1'b1;
    @(negedge clk);
    t_areg();
    t_brief();
    t_pc();
    t_mem();
    t_imm();
    t_full();
    t_overlap();
    print_verdict();
  end
endmodule
